// >>> cal_pkg.sv
/*
 Package for the capacity aging and learn logic: register offsets, field
 layouts, reset values, scaling shifts and the learn sequencer states.
 Assumes the coulomb count, the model lookups and the measurements are
 produced elsewhere in the device.
*/
package cal_pkg;

   // Register offsets on the internal register port
   localparam logic [7:0] ADDR_SENSE = 8'h00;
   localparam logic [7:0] ADDR_CHARGE_VOLTAGE_LIMIT_LIM = 8'h01;
   localparam logic [7:0] ADDR_TERM_LIM = 8'h02;
   localparam logic [7:0] ADDR_AE_VLIM = 8'h03;
   localparam logic [7:0] ADDR_AE_ILIM = 8'h04;
   localparam logic [7:0] ADDR_BUDGET_HI = 8'h05;
   localparam logic [7:0] ADDR_BUDGET_LO = 8'h06;
   localparam logic [7:0] ADDR_WEAR = 8'h07;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // Status register bit positions
   localparam int STAT_FULL_BIT = 7;
   localparam int STAT_AE_BIT = 6;
   localparam int STAT_LEARN_BIT = 4;

   // Wear factor codes, 2^-7 per step
   localparam logic [7:0] WF_UNAGED = 8'h80;
   localparam logic [7:0] WF_FLOOR = 8'h40;
   localparam int WF_FRAC = 7;

   // Aging interval is 32 times the rated wear budget
   localparam int AGE_SHIFT = 5;
   localparam int AGE_W = 16 + AGE_SHIFT;

   // Limit byte to measurement LSB scaling
   localparam int VLIM_SHIFT = 2;
   localparam int TERMINATION_CURRENT_LIMIT_SHIFT = 5;
   localparam int IAE_SHIFT = 7;
   localparam logic [14:0] CUR_FULL_MIN = 15'h0010;
   localparam logic [1:0] FULL_READINGS = 2'h2;

   typedef struct packed {
      logic [7:0] sense_conductance;
      logic [7:0] charge_voltage_limit;
      logic [7:0] termination_current_limit;
      logic [7:0] active_empty_voltage_limit;
      logic [7:0] active_empty_current_limit;
      logic [15:0] rated_wear_budget;
      logic [7:0] wear_factor;
   } cal_params_s;

   localparam cal_params_s PARAM_RST = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, WF_UNAGED};

   typedef struct packed {
      logic [9:0] cell1_voltage;
      logic [9:0] cell2_voltage;
      logic [15:0] averaged_current;
   } cal_meas_s;

   typedef struct packed {
      logic charged_full_flag;
      logic active_empty_flag;
      logic learn_flag;
   } cal_flags_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ADJUST = 3'b010,
      ST_LOAD = 3'b100
   } cal_state_e;

endpackage

// >>> cal_scale.sv
/*
 Scales a full-capacity lookup value by the wear factor.
 Assumes the lookup is in coulomb-count units and the factor is 2^-7 per LSB.
*/
`timescale 1ns/1ns
module cal_scale
   import cal_pkg::*;
(
   input wire logic [15:0] full_value,
   input wire logic [8:0] factor,
   output logic [16:0] scaled
);
   logic [24:0] product;

   // Result keeps one bit above 16 so a factor just over unity cannot wrap
   always_comb begin
      product = full_value * factor;
      scaled = product[WF_FRAC +: 17];
   end
endmodule // cal_scale

// >>> cal_top.sv
/*
 Capacity aging and learn housekeeping: application parameter registers,
 wear factor aging and learning, full and empty detection, coulomb count
 corrections. Assumes synchronous measurement strobes, a coulomb count and
 model lookups from the rest of the device, and a nonvolatile store that
 recalls the parameter image on NV_RECALL.
*/
// How it works
// - Sense conductance byte is held in the parameter block and driven out for results.
// - Termination current limit byte, 50 uV steps, bounds averaged charge current.
// - Active-empty voltage limit byte, 19.5 mV steps, compared with the mean cell voltage.
// - Active-empty current limit byte, 200 uV steps of discharge magnitude.
// - Rated wear budget is two bytes in coulomb-count units.
// - Wear factor byte, 2^-7 per step, 80h means unaged.
// - Decrements never take the wear factor below 40h, they clamp there; host writes and recall can load lower.
// - Host reads and writes the wear factor; it is saved and recalled.
// - Discharge steps count up; at 32 times the budget the wear factor drops.
// - A completed learn cycle clears the aging counter.
// - Active-empty point sets the learn flag; charging must then be uninterrupted.
// - Full during learn clears learn, sets charged-full and adjusts the wear factor.
// - Charged-full loads the wear-scaled full value, after any wear update.
// - Empty flag without learn lowers the count to the empty value only if above.
// - Learn flag at empty loads the count with the active-empty value.
// - Full: mean voltage above limit over two readings, current between 16 LSB and limit.
// - Full detection sets the charged-full status flag.
// - Empty point: voltage below limit after two heavy discharge readings.
// - Empty flag sets on the voltage limit alone.
`timescale 1ns/1ns
module cal_top
   import cal_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   output logic [7:0] REG_RDATA,
   input wire logic NV_RECALL,
   input wire cal_params_s NV_IMAGE,
   output logic NV_WEAR_SAVE,
   input wire logic MEAS_VALID,
   input wire cal_meas_s MEAS,
   input wire logic DISCHARGE_STEP,
   input wire logic [15:0] COUNT,
   input wire logic [15:0] FULL_MODEL,
   input wire logic [15:0] EMPTY_MODEL,
   output logic COUNT_LOAD,
   output logic [15:0] COUNT_LOAD_VALUE,
   output cal_params_s PARAMS,
   output cal_flags_s FLAGS
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta;
   logic rst_n;

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wear scaling

   logic [16:0] full_now;
   logic [16:0] full_up;

   cal_scale u_scale_now (
      .full_value(FULL_MODEL),
      .factor({1'b0, PARAMS.wear_factor}),
      .scaled(full_now)
   );

   cal_scale u_scale_up (
      .full_value(FULL_MODEL),
      .factor(9'({1'b0, PARAMS.wear_factor} + 9'h001)),
      .scaled(full_up)
   );

   ////////////////////////////////////////////////////////////////////////
   // State

   cal_state_e state;
   cal_state_e next_state;
   cal_params_s next_params;
   cal_flags_s next_flags;
   logic [1:0] full_cnt;
   logic [1:0] next_full_cnt;
   logic [1:0] heavy_hist;
   logic [1:0] next_heavy_hist;
   logic learn_charging;
   logic next_learn_charging;
   logic [AGE_W-1:0] age_cnt;
   logic [AGE_W-1:0] next_age_cnt;
   logic next_count_load;
   logic [15:0] next_count_value;
   logic next_nv_save;
   logic [7:0] next_rdata;

   // Measurement decode
   logic [10:0] vsum;
   logic [9:0] vmean;
   logic [15:0] dmag;
   logic cur_neg;
   logic volt_high;
   logic volt_low;
   logic cur_full_ok;
   logic heavy;
   logic empty_point;
   logic full_hit;
   logic [AGE_W-1:0] age_limit;

   always_comb begin
      vsum = {1'b0, MEAS.cell1_voltage} + {1'b0, MEAS.cell2_voltage};
      vmean = vsum[10:1];
      cur_neg = MEAS.averaged_current[15];
      dmag = 16'(~MEAS.averaged_current + 16'h0001);
      volt_high = vmean > {PARAMS.charge_voltage_limit, {VLIM_SHIFT{1'b0}}};
      volt_low = vmean < {PARAMS.active_empty_voltage_limit, {VLIM_SHIFT{1'b0}}};
      cur_full_ok = !cur_neg && MEAS.averaged_current[14:0] > CUR_FULL_MIN
         && MEAS.averaged_current[14:0] < {2'b00, PARAMS.termination_current_limit, {TERMINATION_CURRENT_LIMIT_SHIFT{1'b0}}};
      heavy = cur_neg && dmag > {1'b0, PARAMS.active_empty_current_limit, {IAE_SHIFT{1'b0}}};
      empty_point = volt_low && (&heavy_hist);
      full_hit = MEAS_VALID && volt_high && cur_full_ok && full_cnt == FULL_READINGS - 2'h1;
      age_limit = {PARAMS.rated_wear_budget, {AGE_SHIFT{1'b0}}};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next values

   always_comb begin
      next_state = state;
      next_params = PARAMS;
      next_flags = FLAGS;
      next_full_cnt = full_cnt;
      next_heavy_hist = heavy_hist;
      next_learn_charging = learn_charging;
      next_age_cnt = age_cnt;
      next_count_load = 1'b0;
      next_count_value = COUNT_LOAD_VALUE;

      // Host writes; the sequencer owns the wear factor while adjusting
      if (REG_WR) begin
         case (REG_ADDR)
            ADDR_SENSE: next_params.sense_conductance = REG_WDATA;
            ADDR_CHARGE_VOLTAGE_LIMIT_LIM: next_params.charge_voltage_limit = REG_WDATA;
            ADDR_TERM_LIM: next_params.termination_current_limit = REG_WDATA;
            ADDR_AE_VLIM: next_params.active_empty_voltage_limit = REG_WDATA;
            ADDR_AE_ILIM: next_params.active_empty_current_limit = REG_WDATA;
            ADDR_BUDGET_HI: next_params.rated_wear_budget[15:8] = REG_WDATA;
            ADDR_BUDGET_LO: next_params.rated_wear_budget[7:0] = REG_WDATA;
            ADDR_WEAR: begin
               if (state == ST_IDLE) begin
                  next_params.wear_factor = REG_WDATA;
               end
            end
            default: begin
            end
         endcase
      end

      // Aging from discharge; a zero budget would fire only when the counter wraps, so it disables aging
      if (DISCHARGE_STEP && PARAMS.rated_wear_budget != 16'h0000) begin
         if (AGE_W'(age_cnt + 1'b1) == age_limit) begin
            next_age_cnt = '0;
            if (next_params.wear_factor > WF_FLOOR) begin
               next_params.wear_factor = next_params.wear_factor - 8'h01;
            end
         end else begin
            next_age_cnt = AGE_W'(age_cnt + 1'b1);
         end
      end

      if (MEAS_VALID) begin
         next_heavy_hist = {heavy_hist[0], heavy};
         if (volt_low) begin
            next_flags.active_empty_flag = 1'b1;
         end
         if (cur_neg) begin
            next_flags.charged_full_flag = 1'b0;
         end
         // A discharge after charging began breaks the learn cycle
         if (FLAGS.learn_flag && !cur_neg && MEAS.averaged_current != 16'h0000) begin
            next_learn_charging = 1'b1;
         end
         if (FLAGS.learn_flag && learn_charging && cur_neg) begin
            next_flags.learn_flag = 1'b0;
            next_learn_charging = 1'b0;
         end
         if (volt_high && cur_full_ok) begin
            next_full_cnt = (full_cnt == FULL_READINGS - 2'h1) ? 2'h0 : full_cnt + 2'h1;
         end else begin
            next_full_cnt = 2'h0;
         end
         if (empty_point) begin
            next_flags.learn_flag = 1'b1;
            next_learn_charging = 1'b0;
            next_count_load = 1'b1;
            next_count_value = EMPTY_MODEL;
         end else if (volt_low && !FLAGS.learn_flag && COUNT > EMPTY_MODEL) begin
            next_count_load = 1'b1;
            next_count_value = EMPTY_MODEL;
         end
      end

      case (state)
         ST_IDLE: begin
            if (full_hit) begin
               next_flags.charged_full_flag = 1'b1;
               // An empty flag set by this same reading wins over the clear
               if (!volt_low) begin
                  next_flags.active_empty_flag = 1'b0;
               end
               next_count_load = 1'b0;
               if (FLAGS.learn_flag) begin
                  next_flags.learn_flag = 1'b0;
                  next_learn_charging = 1'b0;
                  next_state = ST_ADJUST;
               end else begin
                  next_state = ST_LOAD;
               end
            end
         end
         ST_ADJUST: begin
            // One step a cycle until the scaled full value brackets the learned count
            if (PARAMS.wear_factor < WF_UNAGED && full_up <= {1'b0, COUNT}) begin
               next_params.wear_factor = PARAMS.wear_factor + 8'h01;
            end else if (PARAMS.wear_factor > WF_FLOOR && full_now > {1'b0, COUNT}) begin
               next_params.wear_factor = PARAMS.wear_factor - 8'h01;
            end else begin
               next_params.wear_factor = PARAMS.wear_factor;
               next_age_cnt = '0;
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            next_count_load = 1'b1;
            next_count_value = (full_now[16]) ? 16'hFFFF : full_now[15:0];
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase

      // Power-up recall of the whole parameter image wins over everything else
      if (NV_RECALL) begin
         next_params = NV_IMAGE;
      end

      next_nv_save = !NV_RECALL && next_params.wear_factor != PARAMS.wear_factor;

      case (REG_ADDR)
         ADDR_SENSE: next_rdata = PARAMS.sense_conductance;
         ADDR_CHARGE_VOLTAGE_LIMIT_LIM: next_rdata = PARAMS.charge_voltage_limit;
         ADDR_TERM_LIM: next_rdata = PARAMS.termination_current_limit;
         ADDR_AE_VLIM: next_rdata = PARAMS.active_empty_voltage_limit;
         ADDR_AE_ILIM: next_rdata = PARAMS.active_empty_current_limit;
         ADDR_BUDGET_HI: next_rdata = PARAMS.rated_wear_budget[15:8];
         ADDR_BUDGET_LO: next_rdata = PARAMS.rated_wear_budget[7:0];
         ADDR_WEAR: next_rdata = PARAMS.wear_factor;
         ADDR_STATUS: begin
            next_rdata = 8'h00;
            next_rdata[STAT_FULL_BIT] = FLAGS.charged_full_flag;
            next_rdata[STAT_AE_BIT] = FLAGS.active_empty_flag;
            next_rdata[STAT_LEARN_BIT] = FLAGS.learn_flag;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         PARAMS <= PARAM_RST;
         FLAGS <= '0;
         full_cnt <= 2'h0;
         heavy_hist <= 2'h0;
         learn_charging <= 1'b0;
         age_cnt <= '0;
         COUNT_LOAD <= 1'b0;
         COUNT_LOAD_VALUE <= 16'h0000;
         NV_WEAR_SAVE <= 1'b0;
         REG_RDATA <= 8'h00;
      end else if (CE) begin
         state <= next_state;
         PARAMS <= next_params;
         FLAGS <= next_flags;
         full_cnt <= next_full_cnt;
         heavy_hist <= next_heavy_hist;
         learn_charging <= next_learn_charging;
         age_cnt <= next_age_cnt;
         COUNT_LOAD <= next_count_load;
         COUNT_LOAD_VALUE <= next_count_value;
         NV_WEAR_SAVE <= next_nv_save;
         REG_RDATA <= next_rdata;
      end
   end

endmodule // cal_top

// >>> cal_top_assertions.sv
/*
 Concurrent checks on the cal_top ports, bound into every cal_top instance.
 Assumes a single clock domain and CE held high whenever a checked event occurs.
*/
`timescale 1ns/1ns
module cal_top_assertions
   import cal_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic NV_RECALL,
   input wire cal_params_s NV_IMAGE,
   input wire logic NV_WEAR_SAVE,
   input wire logic MEAS_VALID,
   input wire cal_meas_s MEAS,
   input wire logic [15:0] FULL_MODEL,
   input wire logic [15:0] EMPTY_MODEL,
   input wire logic COUNT_LOAD,
   input wire logic [15:0] COUNT_LOAD_VALUE,
   input wire cal_params_s PARAMS,
   input wire cal_flags_s FLAGS
);
   logic [23:0] prod;
   logic [15:0] full_scaled;
   logic [10:0] vsum;
   // Voltage sum is compared against 8x the byte to dodge the mean's rounding
   assign prod = FULL_MODEL * PARAMS.wear_factor;
   assign full_scaled = prod[23] ? 16'hFFFF : prod[22:7];
   assign vsum = MEAS.cell1_voltage + MEAS.cell2_voltage;
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);
   chk_sense_write: assert property (
      REG_WR && REG_ADDR == ADDR_SENSE && !NV_RECALL |=> PARAMS.sense_conductance == $past(REG_WDATA))
      else $error("Sense conductance write lost");
   chk_nv_recall: assert property (
      NV_RECALL |=> PARAMS == $past(NV_IMAGE))
      else $error("Recall image not loaded");
   chk_wear_saved: assert property (
      !$past(NV_RECALL) && PARAMS.wear_factor != $past(PARAMS.wear_factor) |-> NV_WEAR_SAVE)
      else $error("Wear factor change not saved");
   chk_wear_floor: assert property (
      !$past(NV_RECALL) && !$past(REG_WR) && PARAMS.wear_factor < $past(PARAMS.wear_factor)
      |-> PARAMS.wear_factor >= WF_FLOOR)
      else $error("Wear factor dropped below floor");
   chk_full_qualify: assert property (
      $rose(FLAGS.charged_full_flag) |-> !$past(MEAS.averaged_current[15])
      && $past(MEAS.averaged_current) > 16'h0010
      && $past(MEAS.averaged_current) < {PARAMS.termination_current_limit, 5'h00}
      && $past(vsum) > {PARAMS.charge_voltage_limit, 3'h0})
      else $error("Full set on unqualified reading");
   chk_full_ends_learn: assert property (
      $rose(FLAGS.charged_full_flag) && $past(FLAGS.learn_flag) |-> !FLAGS.learn_flag)
      else $error("Learn flag kept at full");
   chk_full_load: assert property (
      $rose(FLAGS.charged_full_flag) && !$past(FLAGS.learn_flag)
      |=> COUNT_LOAD && COUNT_LOAD_VALUE == full_scaled)
      else $error("Scaled full load missing");
   chk_learn_load: assert property (
      $rose(FLAGS.learn_flag) |-> ##[0:1] (COUNT_LOAD && COUNT_LOAD_VALUE == EMPTY_MODEL))
      else $error("Empty point load missing");
   chk_empty_voltage: assert property (
      MEAS_VALID && vsum < {PARAMS.active_empty_voltage_limit, 3'h0} |=> FLAGS.active_empty_flag)
      else $error("Empty flag not set");
   cover property ($rose(FLAGS.learn_flag));
   cover property ($rose(FLAGS.charged_full_flag));
   cover property (NV_WEAR_SAVE && PARAMS.wear_factor == WF_FLOOR);
endmodule // cal_top_assertions

bind cal_top cal_top_assertions u_chk (.CLK_SYS, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .NV_RECALL,
   .NV_IMAGE, .NV_WEAR_SAVE, .MEAS_VALID, .MEAS, .FULL_MODEL, .EMPTY_MODEL, .COUNT_LOAD,
   .COUNT_LOAD_VALUE, .PARAMS, .FLAGS);

// >>> cal_top_tb.sv
/*
 Self-checking bench for cal_top: registers, recall, aging, full, empty, learn.
 Assumes the checker is bound in; inputs change on the falling clock edge.
*/
`timescale 1ns/1ns
module cal_top_tb;
   import cal_pkg::*;
   logic CLK_SYS = 1'b0;
   logic RSTN = 1'b0;
   logic CE = 1'b1;
   logic [7:0] REG_ADDR = 8'h00;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic [7:0] REG_RDATA;
   logic NV_RECALL = 1'b0;
   cal_params_s NV_IMAGE = '0;
   logic NV_WEAR_SAVE;
   logic MEAS_VALID = 1'b0;
   cal_meas_s MEAS = '0;
   logic DISCHARGE_STEP = 1'b0;
   logic [15:0] COUNT = 16'h0000;
   logic [15:0] FULL_MODEL = 16'h1000;
   logic [15:0] EMPTY_MODEL = 16'h0200;
   logic COUNT_LOAD;
   logic [15:0] COUNT_LOAD_VALUE;
   cal_params_s PARAMS;
   cal_flags_s FLAGS;
   int failures = 0;
   int n_compared = 0;
   int n_loads = 0;
   int n_saves = 0;
   logic [15:0] last_load = 16'h0000;

   always #25 CLK_SYS = ~CLK_SYS;

   cal_top DUT (.CLK_SYS, .RSTN, .CE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA, .NV_RECALL,
      .NV_IMAGE, .NV_WEAR_SAVE, .MEAS_VALID, .MEAS, .DISCHARGE_STEP, .COUNT, .FULL_MODEL,
      .EMPTY_MODEL, .COUNT_LOAD, .COUNT_LOAD_VALUE, .PARAMS, .FLAGS);

   // Pulses are caught mid-cycle so their exact edge need not be predicted
   always @(negedge CLK_SYS) begin
      if (COUNT_LOAD === 1'b1) begin
         n_loads++;
         last_load = COUNT_LOAD_VALUE;
      end
      if (NV_WEAR_SAVE === 1'b1) n_saves++;
   end
   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLK_SYS);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge CLK_SYS);
      REG_WR = 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge CLK_SYS);
      REG_ADDR = a;
      cycles(2);
      d = REG_RDATA;
   endtask
   task automatic reading(input logic [9:0] v, input logic [15:0] i);
      @(negedge CLK_SYS);
      MEAS = '{v, v, i};
      MEAS_VALID = 1'b1;
      @(negedge CLK_SYS);
      MEAS_VALID = 1'b0;
      cycles(2);
   endtask
   task automatic steps(input int n);
      repeat (n) begin
         @(negedge CLK_SYS);
         DISCHARGE_STEP = 1'b1;
         @(negedge CLK_SYS);
         DISCHARGE_STEP = 1'b0;
      end
      cycles(3);
   endtask
   task automatic wait_load(input int n0);
      for (int k = 0; k < 300 && n_loads == n0; k++) cycles(1);
      check(n_loads > n0, "no count load");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] d;
      int s0;
      for (int a = 0; a < 10; a++) begin
         reg_read(8'(a), d);
         check(d === ((a == 7) ? WF_UNAGED : 8'h00), "reset value");
      end
      s0 = n_saves;
      for (int a = 0; a < 8; a++) begin
         reg_write(8'(a), 8'h50 + 8'(a));
         reg_read(8'(a), d);
         check(d === 8'h50 + 8'(a), "readback");
      end
      check(PARAMS === cal_params_s'{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 16'h5556, 8'h57}, "params");
      check(n_saves == s0 + 1, "wear save pulse");
      reg_write(ADDR_STATUS, 8'hFF);
      reg_read(ADDR_STATUS, d);
      check(d === 8'h00, "status writable");
      reg_write(8'h0A, 8'hFF);
      reg_read(8'h0A, d);
      check(d === 8'h00, "unmapped read");
   endtask
   task automatic t_recall();
      NV_IMAGE = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 16'h6677, 8'h78};
      @(negedge CLK_SYS);
      NV_RECALL = 1'b1;
      @(negedge CLK_SYS);
      NV_RECALL = 1'b0;
      cycles(1);
      check(PARAMS === NV_IMAGE, "recall");
      // A write while the clock enable is low must be lost
      CE = 1'b0;
      reg_write(ADDR_AE_ILIM, 8'h00);
      check(PARAMS === NV_IMAGE, "write while frozen");
      CE = 1'b1;
   endtask
   task automatic t_aging();
      steps(31);
      check(PARAMS.wear_factor === 8'h41, "early aging step");
      steps(1);
      check(PARAMS.wear_factor === 8'h40, "aging step missing");
      steps(32);
      check(PARAMS.wear_factor === WF_FLOOR, "below floor");
      reg_write(ADDR_WEAR, 8'h50);
      steps(31);
      check(PARAMS.wear_factor === 8'h50, "aging count not restarted");
      steps(1);
      check(PARAMS.wear_factor === 8'h4F, "aging step missing");
   endtask
   task automatic t_full();
      logic [7:0] d;
      int n0;
      reg_write(ADDR_WEAR, WF_UNAGED);
      reading(10'h384, 16'h0064);
      reading(10'h384, 16'h0010);
      reading(10'h384, 16'h0064);
      reading(10'h384, 16'h0200);
      reading(10'h384, 16'h0064);
      reading(10'h35C, 16'h0064);
      reading(10'h384, 16'h0064);
      check(FLAGS.charged_full_flag === 1'b0, "full on bad readings");
      n0 = n_loads;
      reading(10'h384, 16'h0064);
      check(FLAGS.charged_full_flag === 1'b1, "full missed");
      reg_read(ADDR_STATUS, d);
      check(d[STAT_FULL_BIT] === 1'b1, "status full bit");
      wait_load(n0);
      check(last_load === 16'h1000, "full load value");
   endtask
   task automatic t_empty();
      int n0;
      COUNT = 16'h0300;
      reading(10'h2BC, 16'hFE00);
      reading(10'h2BC, 16'hFE00);
      n0 = n_loads;
      reading(10'h258, 16'hFE00);
      check(FLAGS === 3'b010, "empty flags");
      wait_load(n0);
      check(last_load === 16'h0200, "empty load value");
      COUNT = 16'h0100;
      n0 = n_loads;
      reading(10'h258, 16'hFE00);
      cycles(4);
      check(n_loads == n0, "count raised to empty");
   endtask
   task automatic t_learn();
      int n0;
      reg_write(ADDR_WEAR, 8'h7A);
      steps(20);
      reading(10'h2BC, 16'hFDA8);
      reading(10'h2BC, 16'hFDA8);
      n0 = n_loads;
      reading(10'h258, 16'hFDA8);
      check(FLAGS.learn_flag === 1'b1, "learn not set");
      wait_load(n0);
      check(last_load === 16'h0200, "empty point load");
      COUNT = 16'h0E00;
      reading(10'h384, 16'h0064);
      n0 = n_loads;
      reading(10'h384, 16'h0064);
      check(FLAGS.learn_flag === 1'b0 && FLAGS.charged_full_flag === 1'b1, "learn end");
      wait_load(n0);
      check(PARAMS.wear_factor === 8'h70 && last_load === 16'h0E00, "learned full");
      steps(20);
      check(PARAMS.wear_factor === 8'h70, "aging count kept");
      reading(10'h2BC, 16'hFDA8);
      reading(10'h2BC, 16'hFDA8);
      reading(10'h258, 16'hFDA8);
      check(FLAGS.learn_flag === 1'b1, "second learn not set");
      COUNT = 16'h0F80;
      reading(10'h384, 16'h0064);
      n0 = n_loads;
      reading(10'h384, 16'h0064);
      wait_load(n0);
      check(PARAMS.wear_factor === 8'h7C && last_load === 16'h0F80, "learned larger");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      failures++;
      conclude();
   end
   initial begin
      cycles(6);
      RSTN = 1'b1;
      cycles(3);
      t_regs();
      t_recall();
      reg_write(ADDR_CHARGE_VOLTAGE_LIMIT_LIM, 8'hD7);
      reg_write(ADDR_TERM_LIM, 8'h10);
      reg_write(ADDR_AE_VLIM, 8'h9A);
      reg_write(ADDR_AE_ILIM, 8'h04);
      reg_write(ADDR_BUDGET_HI, 8'h00);
      reg_write(ADDR_BUDGET_LO, 8'h01);
      reg_write(ADDR_WEAR, 8'h41);
      t_aging();
      t_full();
      t_empty();
      t_learn();
      conclude();
   end
endmodule // cal_top_tb
